// *** pkg/boot_pkg.sv ***
// constants and types shared by the spi boot loader command block
package boot_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // command codes
  localparam logic [15:0] CMD_WR_SINGLE    = 16'h0000;
  localparam logic [15:0] CMD_WR_BURST     = 16'h0001;
  localparam logic [15:0] CMD_RD_BURST     = 16'h0002;
  localparam logic [15:0] CMD_RD_SINGLE    = 16'h0003;
  localparam logic [15:0] CMD_PKT_COUNT    = 16'h0004;
  localparam logic [15:0] CMD_IV           = 16'h0005;
  localparam logic [15:0] CMD_SIG          = 16'h0006;
  localparam logic [15:0] CMD_FUSE_BUF     = 16'h0007;
  localparam logic [15:0] CMD_BUF_TO_KEY   = 16'h0008;
  localparam logic [15:0] CMD_BUF_TO_AUTH  = 16'h0009;
  localparam logic [15:0] CMD_BUF_TO_CTRL  = 16'h000B;
  localparam logic [15:0] CMD_BLOW         = 16'h000C;
  localparam logic [15:0] CMD_KEY_TO_SHD   = 16'h000D;
  localparam logic [15:0] CMD_AUTH_TO_SHD  = 16'h000E;
  localparam logic [15:0] CMD_CTRL_TO_SHD  = 16'h0010;
  localparam logic [15:0] CMD_SHD_READ     = 16'h0011;
  localparam logic [15:0] CMD_STATUS       = 16'h0012;
  localparam logic [15:0] CMD_DECRYPT      = 16'h0013;
  localparam logic [15:0] CMD_MASTER_WIN   = 16'h0014;
  localparam logic [15:0] CMD_DECRYPT_PLUS = 16'h0015;
  localparam logic [15:0] CMD_HANDOFF      = 16'hA55A;
  localparam logic [15:0] CMD_HANDOFF_STOP = 16'hA66A;
  localparam logic [15:0] CMD_UNLOCK       = 16'hDE05;

  ////////////////////////////////////////////////////////////////////////////
  // password, frame layout, field positions
  localparam logic [31:0] UNLOCK_KEY1     = 32'h5345ACBA;
  localparam logic [31:0] UNLOCK_KEY2     = 32'hACBA5345;
  localparam logic [5:0]  HDR_BITS        = 6'h30;
  localparam int          ACK_SIGN_LSB    = 17;
  localparam int          ACK_CAUSE_LSB   = 14;
  localparam int          STATUS_BUSY_BIT = 0;
  localparam int          CTRL_SECURE_BIT = 0;
  localparam logic [31:0] WORD_STEP       = 32'h4;
  localparam logic [1:0]  BANK_KEY        = 2'h0;
  localparam logic [1:0]  BANK_AUTH       = 2'h1;
  localparam logic [1:0]  BANK_CTRL       = 2'h2;

  ////////////////////////////////////////////////////////////////////////////
  // reset values and timing
  localparam logic [127:0] BANK_RST       = 128'h0;
  localparam logic [15:0]  PKT_RST        = 16'h0;
  localparam int           MCLK_MHZ       = 100;
  localparam int           SCLK_MAX_MHZ   = 16;
  localparam int           SCLK_HALF_CYC  = MCLK_MHZ / (2 * SCLK_MAX_MHZ);
  localparam int           RST_HOLD_NS    = 160;
  localparam int           RST_HOLD_CYC   = (RST_HOLD_NS * MCLK_MHZ + 999) / 1000;
  localparam logic [7:0]   RST_HOLD_CNT   = 8'(RST_HOLD_CYC);

  typedef enum logic [1:0] {L_LOCKED, L_HALF, L_OPEN} lock_t;
  typedef enum logic [1:0] {PH_ADDR, PH_CMD, PH_DATA} phase_t;

endpackage : boot_pkg

// *** pkg/spi_link_if.sv ***
// byte stream and answer word between the spi sampler and the interpreter
`timescale 1ns/1ns
interface spi_link_if;
  logic        frame_start;
  logic        frame_end;
  logic        byte_valid;
  logic [7:0]  rx_byte;
  logic        miso;
  logic        tx_load;
  logic [31:0] tx_word;
  modport rx  (output frame_start, frame_end, byte_valid, rx_byte, miso,
               input tx_load, tx_word);
  modport cmd (input frame_start, frame_end, byte_valid, rx_byte, miso,
               output tx_load, tx_word);
endinterface : spi_link_if

// *** verilog/spi_frame_rx.sv ***
// spi mode 0 sampler: synchronisers, byte shifter and answer shifter
`timescale 1ns/1ns
module spi_frame_rx
  import boot_pkg::*;
(
  input  wire logic mclk,
  input  wire logic rst,
  input  wire logic spi_sclk,
  input  wire logic spi_chip_select_n,
  input  wire logic spi_mosi,
  spi_link_if.rx    lnk
);

  typedef struct packed {
    logic [2:0]  sck;
    logic [1:0]  cs;
    logic [1:0]  mo;
    logic        active;
    logic [2:0]  bitc;
    logic [7:0]  sh;
    logic [5:0]  hdr;
    logic [4:0]  slot;
    logic [31:0] tx;
    logic        miso;
    logic        fs;
    logic        fe;
    logic        bv;
    logic [7:0]  rx;
  } rx_t;

  rx_t q, d;
  logic rise, fall;

  // bytes go out low byte first, each byte msb first
  function automatic logic [4:0] tx_idx(input logic [4:0] s);
    tx_idx = {s[4:3], ~s[2:0]};
  endfunction : tx_idx

  ////////////////////////////////////////////////////////////////////////////
  // sck is only sampled; edges are found after the two-flop stage
  assign rise = q.sck[1] & ~q.sck[2]; // RULE7 RULE8
  assign fall = ~q.sck[1] & q.sck[2]; // RULE8

  always_comb begin
    d = q;
    d.sck = {q.sck[1:0], spi_sclk};
    d.cs = {q.cs[0], spi_chip_select_n};
    d.mo = {q.mo[0], spi_mosi};
    d.fs = 1'b0;
    d.fe = 1'b0;
    d.bv = 1'b0;
    if (!q.cs[1] && !q.active) begin
      d.active = 1'b1; // RULE26
      d.fs = 1'b1;
      d.bitc = 3'h0;
      d.hdr = 6'h0;
      d.slot = 5'h0;
    end else if (q.cs[1] && q.active) begin
      d.active = 1'b0; // RULE26
      d.fe = 1'b1;
    end else if (q.active && rise) begin
      d.sh = {q.sh[6:0], q.mo[1]}; // RULE8
      d.bitc = q.bitc + 3'h1;
      if (q.bitc == 3'h7) begin
        d.bv = 1'b1;
        d.rx = {q.sh[6:0], q.mo[1]};
      end
      d.slot = q.slot + 5'h1;
      if (q.hdr != HDR_BITS) begin
        d.hdr = q.hdr + 6'h1;
        if (q.hdr == HDR_BITS - 6'h1) begin
          d.slot = 5'h0; // RULE9
        end
      end
    end else if (q.active && fall) begin
      d.miso = q.tx[tx_idx(q.slot)]; // RULE8
    end
    if (lnk.tx_load) begin
      d.tx = lnk.tx_word;
      d.miso = lnk.tx_word[tx_idx(q.slot)]; // RULE11
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      q <= '0;
      q.sck <= 3'h0;
      q.cs <= 2'h3;
    end else begin
      q <= d;
    end
  end

  assign lnk.frame_start = q.fs;
  assign lnk.frame_end = q.fe;
  assign lnk.byte_valid = q.bv;
  assign lnk.rx_byte = q.rx;
  assign lnk.miso = q.miso;

  a_start_clears: assert property (@(posedge mclk) disable iff (rst) // RULE26
    q.fs |-> q.bitc == 3'h0 && q.hdr == 6'h0 && q.slot == 5'h0)
    else $error("frame start did not clear the bit counters");

  a_edge_spacing: assert property (@(posedge mclk) disable iff (rst) // RULE7
    rise |=> !rise [*2])
    else $error("sampled clock edges closer than the clock limit");

endmodule : spi_frame_rx

// *** verilog/spi_boot_loader_cmd.sv ***
// spi boot loader command interpreter with fuse and decrypt setup
//
// Function
// RULE1 - reset pin of any length resets everything
// RULE2 - host pads secured image to 16-byte blocks
// RULE3 - authentication uses aes-128 cmac, two coverages
// RULE4 - block count register holds sixteen bits
// RULE5 - decryption uses aes-128 in cbc mode
// RULE6 - secured image runs only after decrypt passes
// RULE7 - logic follows spi clock, at most 16 mhz
// RULE8 - spi mode 0 only, clock idles low
// RULE9 - frame: address, command, then data words
// RULE10 - all frame fields are little endian
// RULE11 - every frame answered with signature word; code sends no answer once CMD_HANDOFF_STOP has set clk_off
// RULE12 - host reaches memories and registers over spi
// RULE13 - single write and consecutive burst write
// RULE14 - single read and open-ended burst read
// RULE15 - host clocks zero bytes during reads
// RULE16 - load packet count, vector and signature
// RULE17 - command loads 128-bit fuse buffer
// RULE18 - copy buffer to shadow, then blow
// RULE19 - load fuse banks into shadow, read back
// RULE20 - decrypt, decrypt plus and master window
// RULE21 - hand miso to core peripheral, stop clock
// RULE22 - stays locked until correct unlock command
// RULE23 - two unlock frames with fixed passwords
// RULE24 - status bit 0 shows fuse write busy
// RULE25 - answer carries signature and reset cause
// RULE26 - chip select starts frame, cut frames dropped
// RULE27 - ignore unknown commands and all while locked
`timescale 1ns/1ns
module spi_boot_loader_cmd
  import boot_pkg::*;
#(
  // arbitrary neutral value, not tied to any part
  parameter logic [14:0] BOOT_SIGN = 15'h1234
) (
  input  wire logic         mclk,
  input  wire logic         rst,
  input  wire logic         external_reset_n,
  input  wire logic         spi_sclk,
  input  wire logic         spi_chip_select_n,
  input  wire logic         spi_mosi,
  output logic              spi_miso,
  input  wire logic         core_spi_miso,
  input  wire logic         user_rst_cause,
  input  wire logic         core_rst_cause,
  input  wire logic         wdt_rst_cause,
  output logic              mem_req,
  output logic              mem_we,
  output logic [31:0]       mem_addr,
  output logic [31:0]       mem_wdata,
  input  wire logic         mem_ack,
  input  wire logic [31:0]  mem_rdata,
  input  wire logic [127:0] cipher_key_fuse_bank,
  input  wire logic [127:0] auth_key_fuse_bank,
  input  wire logic [127:0] ctrl_fuse_bank,
  input  wire logic         fuse_busy,
  output logic              fuse_blow,
  output logic [1:0]        fuse_blow_sel,
  output logic [127:0]      shadow_key,
  output logic [127:0]      shadow_auth,
  output logic [127:0]      shadow_ctrl,
  output logic [15:0]       dec_pkt_count,
  output logic [127:0]      dec_iv,
  output logic [127:0]      dec_sig,
  output logic              dec_start,
  output logic              dec_plus,
  input  wire logic         dec_done,
  input  wire logic         dec_ok,
  output logic              run_permit,
  output logic              master_window,
  output logic              miso_to_core,
  output logic              loader_clk_off,
  output logic              core_reset,
  output logic              periph_reset,
  output logic              unlocked
);

  typedef struct packed {
    logic         ext_s1;
    logic         ext_s2;
    logic [7:0]   hold;
    logic         core_reset;
    logic         periph_reset;
    logic         blk_rst;
    lock_t        lock;
    phase_t       ph;
    logic [1:0]   bcnt;
    logic [1:0]   widx;
    logic [31:0]  addr;
    logic [15:0]  cmd;
    logic [31:0]  word;
    logic         rd_pend;
    logic         mem_req;
    logic         mem_we;
    logic [31:0]  mem_addr;
    logic [31:0]  mem_wdata;
    logic [15:0]  pkt;
    logic [127:0] iv;
    logic [127:0] sig;
    logic [127:0] fbuf;
    logic [127:0] shd_key;
    logic [127:0] shd_auth;
    logic [127:0] shd_ctrl;
    logic [1:0]   shd_sel;
    logic         blow;
    logic         dec_start;
    logic         dec_plus;
    logic         dec_pass;
    logic         run;
    logic         mwin;
    logic         miso_core;
    logic         clk_off;
    logic         miso;
    logic         tx_load;
    logic [31:0]  tx_word;
    logic         open;
  } st_t;

  st_t         q, d;
  logic        ext_seen_q;
  logic        srst;
  logic        hdr_go;
  logic        word_go;
  logic        act;
  logic [31:0] word_w;
  logic [31:0] ack_w;

  spi_link_if lnk ();

  spi_frame_rx u_rx (
    .mclk              (mclk),
    .rst               (q.blk_rst),
    .spi_sclk          (spi_sclk),
    .spi_chip_select_n (spi_chip_select_n),
    .spi_mosi          (spi_mosi),
    .lnk               (lnk.rx)
  );

  function automatic logic [31:0] shd_word(input st_t s,
                                           input logic [1:0] idx);
    logic [127:0] b;
    b = s.shd_sel == BANK_KEY  ? s.shd_key :
        s.shd_sel == BANK_AUTH ? s.shd_auth : s.shd_ctrl;
    shd_word = b[32*idx +: 32];
  endfunction : shd_word

  ////////////////////////////////////////////////////////////////////////////
  // reset pin catcher: a pulse shorter than a clock still sets it
  always_ff @(posedge mclk or negedge external_reset_n) begin
    if (!external_reset_n) begin
      ext_seen_q <= 1'b1; // RULE1
    end else begin
      ext_seen_q <= 1'b0;
    end
  end

  assign srst = rst | q.ext_s2;
  assign word_w = {lnk.rx_byte, q.word[31:8]}; // RULE10
  assign ack_w = {BOOT_SIGN, user_rst_cause, core_rst_cause, // RULE25
                  wdt_rst_cause, 14'h0};

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    d = q;
    hdr_go = 1'b0;
    word_go = 1'b0;
    act = 1'b0;
    d.tx_load = 1'b0;
    d.blow = 1'b0;
    d.dec_start = 1'b0;
    d.dec_plus = 1'b0;
    d.ext_s1 = ext_seen_q;
    d.ext_s2 = q.ext_s1;
    d.blk_rst = srst;
    if (q.ext_s2) begin
      d.hold = RST_HOLD_CNT; // RULE1
    end else if (q.hold != 8'h0) begin
      d.hold = q.hold - 8'h1;
    end
    d.core_reset = q.ext_s2 || q.hold != 8'h0; // RULE1
    d.periph_reset = q.ext_s2 || q.hold != 8'h0; // RULE1
    d.miso = q.miso_core ? core_spi_miso : lnk.miso; // RULE21
    d.run = !ctrl_fuse_bank[CTRL_SECURE_BIT] || q.dec_pass; // RULE6

    // memory handshake; read data becomes the next answer word
    if (q.mem_req && mem_ack) begin
      d.mem_req = 1'b0;
      if (!q.mem_we && q.rd_pend) begin
        d.tx_load = 1'b1; // RULE14
        d.tx_word = mem_rdata;
        d.rd_pend = 1'b0;
      end
    end

    // a frame cut short simply loses its partial word
    if (lnk.frame_start || lnk.frame_end) begin
      d.ph = PH_ADDR; // RULE26
      d.bcnt = 2'h0;
      d.widx = 2'h0;
      d.rd_pend = 1'b0;
    end
    if (lnk.frame_start && !q.clk_off) begin
      d.tx_load = 1'b1; // RULE11
      d.tx_word = ack_w;
    end

    if (lnk.byte_valid && !q.clk_off) begin
      d.bcnt = q.bcnt + 2'h1;
      case (q.ph)
        PH_ADDR: begin
          d.addr = {lnk.rx_byte, q.addr[31:8]}; // RULE9 RULE10
          if (q.bcnt == 2'h3) begin
            d.ph = PH_CMD;
          end
        end
        PH_CMD: begin
          d.cmd = {lnk.rx_byte, q.cmd[15:8]}; // RULE9 RULE10
          if (q.bcnt == 2'h1) begin
            d.ph = PH_DATA;
            d.bcnt = 2'h0;
            hdr_go = 1'b1;
          end
        end
        PH_DATA: begin
          d.word = word_w;
          if (q.bcnt == 2'h3) begin
            word_go = 1'b1;
          end
        end
        default: d.ph = PH_ADDR;
      endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // header complete: actions that need no data word
    if (hdr_go) begin
      act = q.lock == L_OPEN; // RULE22 RULE27
      if (act) begin
        case (d.cmd)
          CMD_RD_SINGLE, CMD_RD_BURST: begin
            d.mem_req = 1'b1; // RULE12 RULE14
            d.mem_we = 1'b0;
            d.mem_addr = q.addr;
            d.rd_pend = 1'b1;
          end
          CMD_STATUS: begin
            d.tx_load = 1'b1; // RULE24
            d.tx_word = 32'h0;
            d.tx_word[STATUS_BUSY_BIT] = fuse_busy;
          end
          CMD_SHD_READ: begin
            d.tx_load = 1'b1; // RULE19
            d.tx_word = shd_word(q, 2'h0);
          end
          CMD_BUF_TO_KEY: begin
            d.shd_key = q.fbuf; // RULE18
            d.shd_sel = BANK_KEY;
          end
          CMD_BUF_TO_AUTH: begin
            d.shd_auth = q.fbuf; // RULE18
            d.shd_sel = BANK_AUTH;
          end
          CMD_BUF_TO_CTRL: begin
            d.shd_ctrl = q.fbuf; // RULE18
            d.shd_sel = BANK_CTRL;
          end
          CMD_BLOW: d.blow = 1'b1; // RULE18
          CMD_KEY_TO_SHD: begin
            d.shd_key = cipher_key_fuse_bank; // RULE19
            d.shd_sel = BANK_KEY;
          end
          CMD_AUTH_TO_SHD: begin
            d.shd_auth = auth_key_fuse_bank; // RULE19
            d.shd_sel = BANK_AUTH;
          end
          CMD_CTRL_TO_SHD: begin
            d.shd_ctrl = ctrl_fuse_bank; // RULE19
            d.shd_sel = BANK_CTRL;
          end
          CMD_DECRYPT: begin
            d.dec_start = 1'b1; // RULE3 RULE5 RULE20
            d.dec_pass = 1'b0;
          end
          CMD_DECRYPT_PLUS: begin
            d.dec_start = 1'b1; // RULE3 RULE5 RULE20
            d.dec_plus = 1'b1;
            d.dec_pass = 1'b0;
          end
          CMD_MASTER_WIN: d.mwin = !q.mwin; // RULE20
          CMD_HANDOFF: d.miso_core = 1'b1; // RULE21
          CMD_HANDOFF_STOP: begin
            d.miso_core = 1'b1; // RULE21
            d.clk_off = 1'b1;
          end
          default: d.mwin = q.mwin; // RULE27
        endcase
      end
    end

    ////////////////////////////////////////////////////////////////////////
    // one data word complete
    if (word_go) begin
      act = q.lock == L_OPEN; // RULE22 RULE27
      if (q.widx != 2'h3) begin
        d.widx = q.widx + 2'h1;
      end
      if (q.cmd == CMD_UNLOCK && q.widx == 2'h0) begin
        if (q.lock == L_LOCKED && word_w == UNLOCK_KEY1) begin
          d.lock = L_HALF; // RULE23
        end else if (q.lock == L_HALF && word_w == UNLOCK_KEY2) begin
          d.lock = L_OPEN; // RULE22 RULE23
        end else if (q.lock != L_OPEN) begin
          d.lock = L_LOCKED; // RULE23
        end
      end else if (act) begin
        case (q.cmd)
          CMD_WR_SINGLE, CMD_WR_BURST: begin
            if (q.cmd == CMD_WR_BURST || q.widx == 2'h0) begin
              d.mem_req = 1'b1; // RULE12 RULE13
              d.mem_we = 1'b1;
              d.mem_addr = q.addr;
              d.mem_wdata = word_w;
              d.addr = q.addr + WORD_STEP; // RULE13
            end
          end
          CMD_RD_BURST: begin
            d.mem_req = 1'b1; // RULE14 RULE15
            d.mem_we = 1'b0;
            d.mem_addr = q.addr + WORD_STEP;
            d.addr = q.addr + WORD_STEP;
            d.rd_pend = 1'b1;
          end
          CMD_PKT_COUNT: begin
            if (q.widx == 2'h0) begin
              d.pkt = word_w[15:0]; // RULE4 RULE16
            end
          end
          CMD_IV: d.iv[32*q.widx +: 32] = word_w; // RULE16
          CMD_SIG: d.sig[32*q.widx +: 32] = word_w; // RULE16
          CMD_FUSE_BUF: d.fbuf[32*q.widx +: 32] = word_w; // RULE17
          CMD_SHD_READ: begin
            d.tx_load = 1'b1; // RULE19
            d.tx_word = shd_word(q, d.widx);
          end
          default: d.widx = d.widx; // RULE27
        endcase
      end
    end

    // a pass reported in the same cycle as a new start is kept
    if (dec_done && dec_ok) begin
      d.dec_pass = 1'b1; // RULE6
    end
    d.open = d.lock == L_OPEN; // RULE22
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      q <= '0;
      q.ext_s1 <= d.ext_s1;
      q.ext_s2 <= d.ext_s2;
      // plain rst clears the stretch; the pin keeps it running
      q.hold <= rst && !q.ext_s2 ? 8'h0 : d.hold;
      q.core_reset <= d.core_reset;
      q.periph_reset <= d.periph_reset;
      q.blk_rst <= 1'b1;
      q.lock <= L_LOCKED;
      q.ph <= PH_ADDR;
      q.pkt <= PKT_RST;
      q.shd_key <= BANK_RST;
      q.shd_auth <= BANK_RST;
      q.shd_ctrl <= BANK_RST;
    end else begin
      q <= d;
    end
  end

  assign spi_miso = q.miso;
  assign mem_req = q.mem_req;
  assign mem_we = q.mem_we;
  assign mem_addr = q.mem_addr;
  assign mem_wdata = q.mem_wdata;
  assign fuse_blow = q.blow;
  assign fuse_blow_sel = q.shd_sel;
  assign shadow_key = q.shd_key;
  assign shadow_auth = q.shd_auth;
  assign shadow_ctrl = q.shd_ctrl;
  assign dec_pkt_count = q.pkt;
  assign dec_iv = q.iv;
  assign dec_sig = q.sig;
  assign dec_start = q.dec_start;
  assign dec_plus = q.dec_plus;
  assign run_permit = q.run;
  assign master_window = q.mwin;
  assign miso_to_core = q.miso_core;
  assign loader_clk_off = q.clk_off;
  assign core_reset = q.core_reset;
  assign periph_reset = q.periph_reset;
  assign unlocked = q.open;
  assign lnk.tx_load = q.tx_load;
  assign lnk.tx_word = q.tx_word;

  ////////////////////////////////////////////////////////////////////////////
  a_locked_no_access: assert property (@(posedge mclk) disable iff (srst) // RULE22
    $rose(q.mem_req) |-> $past(q.lock) == L_OPEN)
    else $error("memory access while locked");

  a_reset_stretch: assert property (@(posedge mclk) disable iff (rst) // RULE1
    $rose(q.ext_s2) |=> (q.core_reset && q.periph_reset) [*8])
    else $error("core reset not held after reset pin");

  a_ack_on_start: assert property (@(posedge mclk) disable iff (srst) // RULE11
    lnk.frame_start && !q.clk_off |=> q.tx_load &&
      q.tx_word[31:ACK_SIGN_LSB] == BOOT_SIGN)
    else $error("frame start not answered with signature");

  a_status_word: assert property (@(posedge mclk) disable iff (srst) // RULE24
    hdr_go && act && d.cmd == CMD_STATUS |=> q.tx_load &&
      q.tx_word == {31'h0, $past(fuse_busy)})
    else $error("status word wrong");

  a_single_write_once: assert property (@(posedge mclk) disable iff (srst) // RULE13
    word_go && q.cmd == CMD_WR_SINGLE && q.widx != 2'h0 |=> !$rose(q.mem_req))
    else $error("single write wrote a second word");

  a_run_gate: assert property (@(posedge mclk) disable iff (srst) // RULE6
    q.run && ctrl_fuse_bank[CTRL_SECURE_BIT] && $stable(q.run) |-> $past(q.dec_pass))
    else $error("secured image allowed to run without pass");

  a_miso_handoff: assert property (@(posedge mclk) disable iff (srst) // RULE21
    q.miso_core |=> spi_miso == $past(core_spi_miso))
    else $error("miso not following core peripheral");

  a_pkt_load: assert property (@(posedge mclk) disable iff (srst) // RULE16
    word_go && act && q.cmd == CMD_PKT_COUNT && q.widx == 2'h0
      |=> q.pkt == $past(word_w[15:0]))
    else $error("packet count not loaded");

endmodule : spi_boot_loader_cmd

// *** test/spi_host_model.sv ***
// host side spi master model sending mode 0 frames
`timescale 1ns/1ns
module spi_host_model (
  output logic      sclk,
  output logic      cs_n,
  output logic      mosi,
  input  wire logic miso
);
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    mosi = 1'b0;
  end
  // address, command, one data word; bytes low first, msb first in byte
  task automatic frame(input logic [31:0] a, input logic [15:0] c,
      input logic [31:0] d, output logic [31:0] ack, output logic [31:0] rd);
    logic [79:0] tx;
    logic [79:0] rx;
    int          k;
    tx = {d, c, a};
    cs_n = 1'b0;
    #200;
    for (int n = 0; n < 80; n++) begin
      k = 8 * (n / 8) + 7 - n % 8;
      mosi = tx[k];
      #62 sclk = 1'b1;
      rx[k] = miso;
      #63 sclk = 1'b0;
    end
    #100 cs_n = 1'b1;
    // released line shows the inverse, never a held value
    mosi = ~mosi;
    #200;
    ack = rx[31:0];
    rd = rx[79:48];
  endtask : frame
endmodule : spi_host_model

// *** test/tb.sv ***
// self-checking bench for the spi boot loader command block
`timescale 1ns/1ns
module tb;
  import boot_pkg::*;
  localparam logic [14:0] SIGN = 15'h1234; // arbitrary value
  logic         mclk, rst, ext_n, sclk, cs_n, mosi, miso, mem_req, mem_we;
  logic         mem_ack, busy, ucause, m2core, unl, crst, cmiso;
  logic [31:0]  maddr, mwdata, mrdata, ack, rd, req_n;
  logic [127:0] kbank, skey;
  logic [15:0]  pkt;
  logic [1:0]   bsel;
  int           err_count, num_checks, cyc;
  spi_host_model host (.sclk(sclk), .cs_n(cs_n), .mosi(mosi), .miso(miso));
  spi_boot_loader_cmd #(.BOOT_SIGN(SIGN)) dut (.mclk(mclk), .rst(rst),
    .external_reset_n(ext_n), .spi_sclk(sclk), .spi_chip_select_n(cs_n),
    .spi_mosi(mosi), .spi_miso(miso), .core_spi_miso(cmiso),
    .user_rst_cause(ucause), .core_rst_cause(1'b0), .wdt_rst_cause(1'b0),
    .mem_req(mem_req), .mem_we(mem_we), .mem_addr(maddr),
    .mem_wdata(mwdata), .mem_ack(mem_ack), .mem_rdata(mrdata),
    .cipher_key_fuse_bank(kbank), .auth_key_fuse_bank(~kbank),
    .ctrl_fuse_bank(128'h0), .fuse_busy(busy), .fuse_blow(),
    .fuse_blow_sel(bsel), .shadow_key(skey), .shadow_auth(),
    .shadow_ctrl(), .dec_pkt_count(pkt), .dec_iv(), .dec_sig(),
    .dec_start(), .dec_plus(), .dec_done(1'b0), .dec_ok(1'b0),
    .run_permit(), .master_window(), .miso_to_core(m2core),
    .loader_clk_off(), .core_reset(crst), .periph_reset(), .unlocked(unl));
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  // memory answers one cycle after each request
  always @(posedge mclk) begin
    mem_ack <= !rst && mem_req && !mem_ack;
    if (rst) req_n <= 32'h0;
    else if (mem_req && !mem_ack) req_n <= req_n + 32'h1;
    cyc <= rst ? 0 : cyc + 1;
    if (cyc == 60000) begin
      err_count++;
      results();
    end
  end
  task automatic chk(input string nm, input logic [31:0] e,
      input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic t_locked();
    host.frame(32'h100, CMD_WR_SINGLE, 32'h11, ack, rd);
    chk("locked_req", 32'h0, req_n);
    chk("unlocked", 32'h0, 32'(unl));
    chk("ack", {SIGN, 3'b100, 14'h0}, ack);
  endtask : t_locked
  task automatic t_unlock();
    host.frame(32'h0, CMD_UNLOCK, UNLOCK_KEY1, ack, rd);
    chk("half", 32'h0, 32'(unl));
    host.frame(32'h0, CMD_UNLOCK, UNLOCK_KEY2, ack, rd);
    chk("open", 32'h1, 32'(unl));
  endtask : t_unlock
  task automatic t_write();
    host.frame(32'h0000_0104, CMD_WR_SINGLE, 32'hA5C3_1234, ack, rd);
    chk("wr_n", 32'h1, req_n);
    chk("wr_addr", 32'h0000_0104, maddr);
    chk("wr_data", 32'hA5C3_1234, mwdata);
    chk("wr_we", 32'h1, 32'(mem_we));
  endtask : t_write
  task automatic t_read();
    @(posedge mclk) mrdata <= 32'h8765_4321;
    host.frame(32'h0000_0200, CMD_RD_SINGLE, 32'h0, ack, rd);
    chk("rd_data", 32'h8765_4321, rd);
    chk("rd_addr", 32'h0000_0200, maddr);
  endtask : t_read
  task automatic t_setup();
    @(posedge mclk) busy <= 1'b1;
    host.frame(32'h0, CMD_STATUS, 32'h0, ack, rd);
    chk("status", 32'h1, rd);
    host.frame(32'h0, CMD_PKT_COUNT, 32'h0001_0ABC, ack, rd);
    chk("pkt", 32'h0ABC, 32'(pkt));
    host.frame(32'h0, CMD_KEY_TO_SHD, 32'h0, ack, rd);
    chk("shadow", kbank[31:0], skey[31:0]);
    chk("bank", 32'(BANK_KEY), 32'(bsel));
    host.frame(32'h0, CMD_HANDOFF, 32'h0, ack, rd);
    chk("handoff", 32'h1, 32'(m2core));
    @(posedge mclk) cmiso <= 1'b1;
    repeat (3) @(negedge mclk);
    chk("core_miso", 32'h1, 32'(miso));
  endtask : t_setup
  // one-cycle pulse on the pin must still reset and relock
  task automatic t_pin_reset();
    @(posedge mclk) ext_n <= 1'b0;
    @(posedge mclk) ext_n <= 1'b1;
    repeat (4) @(negedge mclk);
    chk("core_rst", 32'h1, 32'(crst));
    repeat (30) @(negedge mclk);
    chk("core_rst_end", 32'h0, 32'(crst));
    chk("relocked", 32'h0, 32'(unl));
    chk("miso_back", 32'h0, 32'(m2core));
  endtask : t_pin_reset
  task automatic results();
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : results
  initial begin
    {err_count, num_checks} = '0;
    {rst, ext_n, ucause, busy, cmiso} = 5'b11100;
    mrdata = '0;
    kbank = {4{32'hC0DE_5A17}};
    repeat (16) @(posedge mclk);
    rst <= 1'b0;
    repeat (8) @(posedge mclk);
    t_locked();
    t_unlock();
    t_write();
    t_read();
    t_setup();
    t_pin_reset();
    results();
  end
endmodule : tb
